// [rtl/sars_pkg.sv]
package sars_pkg;

	localparam logic [6:0] SARS_OWN_ADDR  = 7'h64;
	localparam logic [6:0] SARS_ARA_ADDR  = 7'h0C;
	localparam logic       SARS_RW_READ   = 1'b1;
	localparam logic       SARS_ARA_TAIL  = 1'b1;
	localparam logic [2:0] SARS_LAST_BIT  = 3'h7;
	localparam int         SARS_DW        = 8;
	localparam int         SARS_AW        = 4;
	localparam int         SARS_DEPTH     = 16;
	localparam int         SARS_N_SYNC    = 3;
	localparam int         SARS_SYNC_SCL  = 0;
	localparam int         SARS_SYNC_SDA  = 1;
	localparam int         SARS_SYNC_TGL  = 2;
	localparam logic [7:0] SARS_RST_BYTE  = 8'h00;
	localparam logic [3:0] SARS_RST_PTR   = 4'h0;
	localparam logic [3:0] SARS_PTR_STEP  = 4'h1;
	localparam logic [2:0] SARS_CNT_STEP  = 3'h1;

	typedef enum logic [2:0] {
		SARS_S_IDLE = 3'h0,
		SARS_S_ADDR = 3'h1,
		SARS_S_ACK  = 3'h2,
		SARS_S_RX   = 3'h3,
		SARS_S_TX   = 3'h4,
		SARS_S_MACK = 3'h5
	} sars_state_e;

	typedef enum logic [1:0] {
		SARS_X_WRITE = 2'h0,
		SARS_X_READ  = 2'h1,
		SARS_X_ARA   = 2'h2
	} sars_xfer_e;

	typedef struct packed {
		logic start;
		logic stop;
		logic rise;
		logic fall;
		logic bit_v;
	} sars_bus_ev_s;

endpackage : sars_pkg

// [rtl/sars_link.sv]
`timescale 1ns/1ps
`default_nettype none
// Runs on the serial clock itself; captures the data line at each rising edge.
module sars_link
	import sars_pkg::*;
(
	input  wire logic link_clk,
	input  wire logic sda_i,
	output var  logic bit_reg,
	output var  logic toggle_reg
);

	// The serial clock may be still at reset time, so these start from a fixed value.
	logic cap_reg = 1'b0;
	logic tgl_reg = 1'b0;
	logic bit_next;
	logic toggle_next;

	always_comb begin
		bit_next    = sda_i;
		toggle_next = ~tgl_reg;
	end

	always_ff @(posedge link_clk) begin
		cap_reg <= bit_next;
		tgl_reg <= toggle_next;
	end

	assign bit_reg    = cap_reg;
	assign toggle_reg = tgl_reg;

endmodule : sars_link
`default_nettype wire

// [rtl/sars_regfile.sv]
`timescale 1ns/1ps
`default_nettype none
module sars_regfile
	import sars_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               reset,
	input  wire logic               ce,
	input  wire logic               we,
	input  wire logic [SARS_AW-1:0] waddr,
	input  wire logic [SARS_DW-1:0] wdata,
	input  wire logic [SARS_AW-1:0] raddr,
	output var  logic [SARS_DW-1:0] rdata_reg
);

	logic [SARS_DW-1:0] mem [SARS_DEPTH];
	logic [SARS_DW-1:0] rdata_next;

	always_comb begin
		rdata_next = mem[raddr];
	end

	always_ff @(posedge clk) begin
		if (ce && we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_reg <= SARS_RST_BYTE;
		end else if (ce) begin
			rdata_reg <= rdata_next;
		end
	end

endmodule : sars_regfile
`default_nettype wire

// [rtl/sars_top.sv]
`timescale 1ns/1ps
`default_nettype none
module sars_top
	import sars_pkg::*;
(
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic ce,
	input  wire logic link_clk,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output var  logic sda_o,
	output var  logic sda_oe,
	input  wire logic alert_event,
	input  wire logic alert_mode,
	output var  logic alert_or_charge_done_pin_o,
	output var  logic alert_or_charge_done_pin_oe,
	output var  logic alert_active
);

	logic               link_bit;
	logic               link_toggle;
	logic [SARS_N_SYNC-1:0] sync_in;
	logic [SARS_N_SYNC-1:0] sync1_reg;
	logic [SARS_N_SYNC-1:0] sync2_reg;
	logic [SARS_N_SYNC-1:0] prev_reg;
	logic [SARS_N_SYNC-1:0] prev_next;
	sars_bus_ev_s       ev;

	sars_state_e        state_reg;
	sars_state_e        state_next;
	sars_xfer_e         xfer_reg;
	sars_xfer_e         xfer_next;
	logic [2:0]         cnt_reg;
	logic [2:0]         cnt_next;
	logic [7:0]         shift_reg;
	logic [7:0]         shift_next;
	logic [7:0]         tx_reg;
	logic [7:0]         tx_next;
	logic [SARS_AW-1:0] ptr_reg;
	logic [SARS_AW-1:0] ptr_next;
	logic               cmd_phase_reg;
	logic               cmd_phase_next;
	logic               hold_reg;
	logic               hold_next;
	logic               mack_reg;
	logic               mack_next;
	logic               sda_oe_reg;
	logic               sda_oe_next;
	logic               alert_reg;
	logic               alert_next;
	logic               mem_we;
	logic [7:0]         mem_wdata;
	logic [7:0]         mem_rdata;
	logic [7:0]         rx_byte;

	sars_link sars_link_inst (
		.link_clk   (link_clk),
		.sda_i      (sda_i),
		.bit_reg    (link_bit),
		.toggle_reg (link_toggle)
	);

	sars_regfile sars_regfile_inst (
		.clk       (clk),
		.reset     (reset),
		.ce        (ce),
		.we        (mem_we),
		.waddr     (ptr_reg),
		.wdata     (mem_wdata),
		.raddr     (ptr_reg),
		.rdata_reg (mem_rdata)
	);

	// The clock pin is only ever read here, never driven.
	always_comb begin
		sync_in                = '0;
		sync_in[SARS_SYNC_SCL] = scl_i;
		sync_in[SARS_SYNC_SDA] = sda_i;
		sync_in[SARS_SYNC_TGL] = link_toggle;
	end

	genvar gi;
	generate
		for (gi = 0; gi < SARS_N_SYNC; gi++) begin : g_sync
			always_ff @(posedge clk) begin
				if (reset) begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
				end else if (ce) begin
					sync1_reg[gi] <= sync_in[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	// The captured data bit is stable for the whole high phase of the clock,
	// so it is read only once the toggle has crossed and changed.
	always_comb begin
		prev_next = sync2_reg;
		ev.start  = sync2_reg[SARS_SYNC_SCL] & prev_reg[SARS_SYNC_SCL]
		          & prev_reg[SARS_SYNC_SDA] & ~sync2_reg[SARS_SYNC_SDA];
		ev.stop   = sync2_reg[SARS_SYNC_SCL] & prev_reg[SARS_SYNC_SCL]
		          & ~prev_reg[SARS_SYNC_SDA] & sync2_reg[SARS_SYNC_SDA];
		ev.rise   = sync2_reg[SARS_SYNC_TGL] ^ prev_reg[SARS_SYNC_TGL];
		ev.fall   = prev_reg[SARS_SYNC_SCL] & ~sync2_reg[SARS_SYNC_SCL];
		ev.bit_v  = link_bit;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			prev_reg <= '0;
		end else if (ce) begin
			prev_reg <= prev_next;
		end
	end

	always_comb begin
		rx_byte = {shift_reg[6:0], ev.bit_v};
	end

	always_comb begin
		state_next     = state_reg;
		xfer_next      = xfer_reg;
		cnt_next       = cnt_reg;
		shift_next     = shift_reg;
		tx_next        = tx_reg;
		ptr_next       = ptr_reg;
		cmd_phase_next = cmd_phase_reg;
		hold_next      = hold_reg;
		mack_next      = mack_reg;
		sda_oe_next    = sda_oe_reg;
		alert_next     = alert_reg;
		mem_we         = 1'b0;
		mem_wdata      = rx_byte;
		if (ev.start) begin
			state_next  = SARS_S_ADDR;
			cnt_next    = '0;
			sda_oe_next = 1'b0;
			hold_next   = 1'b0;
		end else if (ev.stop) begin
			state_next  = SARS_S_IDLE;
			sda_oe_next = 1'b0;
		end else begin
			case (state_reg)
				SARS_S_IDLE: begin
					sda_oe_next = 1'b0;
				end
				SARS_S_ADDR: begin
					if (ev.rise) begin
						shift_next = rx_byte;
						cnt_next   = cnt_reg + SARS_CNT_STEP;
						if (cnt_reg == SARS_LAST_BIT) begin
							state_next = SARS_S_IDLE;
							hold_next  = 1'b0;
							if (rx_byte[7:1] == SARS_OWN_ADDR) begin
								state_next     = SARS_S_ACK;
								cmd_phase_next = 1'b1;
								xfer_next      = (rx_byte[0] == SARS_RW_READ) ?
								                 SARS_X_READ : SARS_X_WRITE;
							end else if (rx_byte[7:1] == SARS_ARA_ADDR &&
							             rx_byte[0] == SARS_RW_READ &&
							             alert_reg && alert_mode) begin
								state_next = SARS_S_ACK;
								xfer_next  = SARS_X_ARA;
							end
						end
					end
				end
				SARS_S_ACK: begin
					if (ev.fall && !hold_reg) begin
						sda_oe_next = 1'b1;
						hold_next   = 1'b1;
					end else if (ev.fall) begin
						hold_next = 1'b0;
						cnt_next  = '0;
						if (xfer_reg == SARS_X_WRITE) begin
							sda_oe_next = 1'b0;
							state_next  = SARS_S_RX;
						end else begin
							tx_next     = (xfer_reg == SARS_X_ARA) ?
							              {SARS_OWN_ADDR, SARS_ARA_TAIL} : mem_rdata;
							sda_oe_next = (xfer_reg == SARS_X_ARA) ?
							              ~SARS_OWN_ADDR[6] : ~mem_rdata[7];
							state_next  = SARS_S_TX;
						end
					end
				end
				SARS_S_RX: begin
					if (ev.rise) begin
						shift_next = rx_byte;
						cnt_next   = cnt_reg + SARS_CNT_STEP;
						if (cnt_reg == SARS_LAST_BIT) begin
							state_next = SARS_S_ACK;
							if (cmd_phase_reg) begin
								ptr_next       = rx_byte[SARS_AW-1:0];
								cmd_phase_next = 1'b0;
							end else begin
								mem_we   = 1'b1;
								ptr_next = ptr_reg + SARS_PTR_STEP;
							end
						end
					end
				end
				SARS_S_TX: begin
					if (ev.rise) begin
						if (!sda_oe_reg && !ev.bit_v) begin
							// Lost to a lower address: let go now, alert stays armed.
							state_next  = SARS_S_IDLE;
							sda_oe_next = 1'b0;
						end else begin
							tx_next  = {tx_reg[6:0], 1'b0};
							cnt_next = cnt_reg + SARS_CNT_STEP;
							if (cnt_reg == SARS_LAST_BIT) begin
								state_next = SARS_S_MACK;
								hold_next  = 1'b0;
							end
						end
					end else if (ev.fall) begin
						sda_oe_next = ~tx_reg[7];
					end
				end
				SARS_S_MACK: begin
					if (ev.fall && !hold_reg) begin
						sda_oe_next = 1'b0;
						hold_next   = 1'b1;
					end else if (ev.rise && hold_reg) begin
						mack_next = ~ev.bit_v;
						if (xfer_reg == SARS_X_ARA) begin
							alert_next = 1'b0;
						end else if (!ev.bit_v) begin
							ptr_next = ptr_reg + SARS_PTR_STEP;
						end
					end else if (ev.fall && hold_reg) begin
						hold_next = 1'b0;
						cnt_next  = '0;
						if (mack_reg && xfer_reg == SARS_X_READ) begin
							tx_next     = mem_rdata;
							sda_oe_next = ~mem_rdata[7];
							state_next  = SARS_S_TX;
						end else begin
							state_next = SARS_S_IDLE;
						end
					end
				end
				default: begin
					state_next  = SARS_S_IDLE;
					sda_oe_next = 1'b0;
				end
			endcase
		end
		if (alert_event && alert_mode) begin
			alert_next = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg     <= SARS_S_IDLE;
			xfer_reg      <= SARS_X_WRITE;
			cnt_reg       <= '0;
			shift_reg     <= SARS_RST_BYTE;
			tx_reg        <= SARS_RST_BYTE;
			ptr_reg       <= SARS_RST_PTR;
			cmd_phase_reg <= 1'b0;
			hold_reg      <= 1'b0;
			mack_reg      <= 1'b0;
			sda_oe_reg    <= 1'b0;
			alert_reg     <= 1'b0;
		end else if (ce) begin
			state_reg     <= state_next;
			xfer_reg      <= xfer_next;
			cnt_reg       <= cnt_next;
			shift_reg     <= shift_next;
			tx_reg        <= tx_next;
			ptr_reg       <= ptr_next;
			cmd_phase_reg <= cmd_phase_next;
			hold_reg      <= hold_next;
			mack_reg      <= mack_next;
			sda_oe_reg    <= sda_oe_next;
			alert_reg     <= alert_next;
		end
	end

	// Both lines only ever pull low, so the output data flops hold zero.
	always_ff @(posedge clk) begin
		if (reset) begin
			sda_o                       <= 1'b0;
			alert_or_charge_done_pin_o  <= 1'b0;
			alert_or_charge_done_pin_oe <= 1'b0;
			alert_active                <= 1'b0;
			sda_oe                      <= 1'b0;
		end else if (ce) begin
			sda_o                       <= 1'b0;
			alert_or_charge_done_pin_o  <= 1'b0;
			alert_or_charge_done_pin_oe <= alert_next;
			alert_active                <= alert_next;
			sda_oe                      <= sda_oe_next;
		end
	end

endmodule : sars_top
`default_nettype wire

// [testbench/sars_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module sars_asserts
	import sars_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic alert_event,
	input wire logic alert_mode,
	input wire logic alert_or_charge_done_pin_o,
	input wire logic alert_or_charge_done_pin_oe,
	input wire logic alert_active
);
	wire logic pin_oe = alert_or_charge_done_pin_oe;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence alert_set_s;
		ce && alert_event && alert_mode;
	endsequence
	alert_sets_a: assert property (alert_set_s |=> pin_oe)
		else $error("alert not raised");
	alert_cause_a: assert property ($rose(pin_oe) |-> $past(alert_event && alert_mode))
		else $error("alert rose without event");
	status_match_a: assert property (alert_active == pin_oe)
		else $error("status differs from pin");
	drive_low_a: assert property (!alert_or_charge_done_pin_o && !sda_o)
		else $error("line driven high");
	reset_quiet_a: assert property (disable iff (1'b0) reset |=> !sda_oe && !pin_oe)
		else $error("outputs active after reset");
	ack_timing_a: assert property ($rose(sda_oe) |-> !scl_i && !$past(scl_i, 2))
		else $error("data driven while clock high");
	alert_clear_a: assert property ($fell(pin_oe) |-> scl_i)
		else $error("alert cleared off clock");
	freeze_a: assert property (!ce |=> $stable(sda_oe) && $stable(pin_oe))
		else $error("state moved with ce low");
endmodule : sars_asserts
bind sars_top sars_asserts sars_asserts_inst (.clk, .reset, .ce, .scl_i, .sda_i, .sda_o,
	.sda_oe, .alert_event, .alert_mode, .alert_or_charge_done_pin_o,
	.alert_or_charge_done_pin_oe, .alert_active);
`default_nettype wire

// [testbench/sars_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Bus master plus a second slave that can contend on the data line.
module sars_host_model
	import sars_pkg::*;
(
	input  wire logic clk,
	input  wire logic sda,
	output var  logic scl,
	output var  logic sda_oe,
	output var  logic rival_oe
);
	localparam int HALF = 15;
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
		rival_oe = 1'b0;
	end
	task automatic wt();
		repeat (HALF) @(posedge clk);
	endtask : wt
	// Also serves as a repeated START, since the data line is released first.
	task automatic start();
		sda_oe <= 1'b0;
		wt();
		scl <= 1'b1;
		wt();
		sda_oe <= 1'b1;
		wt();
		scl <= 1'b0;
		wt();
	endtask : start
	task automatic xbit(input logic b, output logic r);
		sda_oe <= !b;
		wt();
		scl <= 1'b1;
		wt();
		r = sda;
		scl <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : xbit
	task automatic xbyte(input logic [7:0] d, output logic [7:0] q);
		for (int i = 7; i >= 0; i--) begin
			xbit(d[i], q[i]);
		end
	endtask : xbyte
	task automatic stop();
		sda_oe <= 1'b1;
		wt();
		scl <= 1'b1;
		wt();
		sda_oe <= 1'b0;
		wt();
	endtask : stop
	task automatic ara(input logic fight, output logic ack, output logic [7:0] q);
		logic nack;
		start();
		xbyte({SARS_ARA_ADDR, SARS_RW_READ}, q);
		xbit(1'b1, ack);
		rival_oe <= fight;
		xbyte(8'hff, q);
		rival_oe <= 1'b0;
		xbit(1'b1, nack);
		stop();
	endtask : ara
endmodule : sars_host_model
`default_nettype wire

// [testbench/sars_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module sars_tb_top
	import sars_pkg::*;
;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        ce = 1'b1;
	logic        alert_event = 1'b0;
	logic        alert_mode = 1'b0;
	logic        sda_oe;
	logic        pin_oe;
	logic        alert_active;
	logic        scl;
	logic        host_oe;
	logic        rival_oe;
	logic [15:0] seed = 16'h22c5;
	int          failures = 0;
	int          checks_done = 0;
	wire logic   sda = ~(sda_oe | host_oe | rival_oe);
	always #10 clk = ~clk;
	sars_top sars_top_inst (.clk, .reset, .ce, .link_clk(scl), .scl_i(scl), .sda_i(sda),
		.sda_o(), .sda_oe, .alert_event, .alert_mode, .alert_or_charge_done_pin_o(),
		.alert_or_charge_done_pin_oe(pin_oe), .alert_active);
	sars_host_model sars_host_model_inst (.clk, .sda, .scl, .sda_oe(host_oe), .rival_oe);
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	function automatic logic [7:0] ara_reply();
		return {SARS_OWN_ADDR, SARS_ARA_TAIL};
	endfunction : ara_reply
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude
	task automatic raise();
		alert_event <= 1'b1;
		@(posedge clk);
		alert_event <= 1'b0;
		@(posedge clk);
	endtask : raise
	task automatic send(input logic [7:0] d);
		logic       a;
		logic [7:0] q;
		sars_host_model_inst.xbyte(d, q);
		sars_host_model_inst.xbit(1'b1, a);
		check({7'h00, a}, 8'h00);
	endtask : send
	task automatic reg_test(input logic [3:0] p, input logic [7:0] d0, input logic [7:0] d1);
		logic       a;
		logic [7:0] q;
		sars_host_model_inst.start();
		send({SARS_OWN_ADDR, 1'b0});
		send({4'h0, p});
		send(d0);
		send(d1);
		sars_host_model_inst.start();
		send({SARS_OWN_ADDR, 1'b0});
		send({4'h0, p});
		sars_host_model_inst.start();
		send({SARS_OWN_ADDR, SARS_RW_READ});
		sars_host_model_inst.xbyte(8'hff, q);
		check(q, d0);
		sars_host_model_inst.xbit(1'b0, a);
		sars_host_model_inst.xbyte(8'hff, q);
		check(q, d1);
		sars_host_model_inst.xbit(1'b1, a);
		sars_host_model_inst.stop();
	endtask : reg_test
	initial begin
		logic       ack;
		logic [7:0] q;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge clk);
		check({6'h00, sda_oe, pin_oe}, 8'h00);
		sars_host_model_inst.ara(1'b0, ack, q);
		check({7'h00, ack}, 8'h01);
		raise();
		ce <= 1'b0;
		alert_mode <= 1'b1;
		raise();
		ce <= 1'b1;
		@(posedge clk);
		check({7'h00, alert_active}, 8'h00);
		$display("test idle_alert done");
		raise();
		check({7'h00, pin_oe}, 8'h01);
		alert_mode <= 1'b0;
		sars_host_model_inst.ara(1'b0, ack, q);
		check({7'h00, ack}, 8'h01);
		alert_mode <= 1'b1;
		sars_host_model_inst.ara(1'b1, ack, q);
		check({7'h00, ack}, 8'h00);
		check(q, 8'h00);
		check({7'h00, alert_active}, 8'h01);
		$display("test arbitration done");
		for (int k = 0; k < 2; k++) begin
			sars_host_model_inst.ara(1'b0, ack, q);
			check({7'h00, ack}, 8'h00);
			check(q, ara_reply());
			check({7'h00, pin_oe}, 8'h00);
			sars_host_model_inst.ara(1'b0, ack, q);
			check({7'h00, ack}, 8'h01);
			raise();
		end
		$display("test alert_response done");
		for (int k = 0; k < 3; k++) begin
			seed = lfsr(seed);
			reg_test((k == 0) ? 4'hf : seed[3:0], seed[15:8], seed[7:0] ^ 8'h5a);
		end
		$display("test registers done");
		conclude();
	end
endmodule : sars_tb_top
`default_nettype wire
